/* inc/rtcc_regs.svh */
// register offsets, field positions, reset values and timing figures of the clock/calendar block
// assumes the serial front end presents byte addresses of the clock/control map
`ifndef RTCC_REGS_SVH
`define RTCC_REGS_SVH

// clock/control map addresses
`define RTCC_ADDR_CTRL 8'h10
`define RTCC_ADDR_SEC 8'h30
`define RTCC_ADDR_MIN 8'h31
`define RTCC_ADDR_HOUR 8'h32
`define RTCC_ADDR_DATE 8'h33
`define RTCC_ADDR_MON 8'h34
`define RTCC_ADDR_YEAR 8'h35
`define RTCC_ADDR_WDAY 8'h36
`define RTCC_ADDR_STATUS 8'h3F

// status register layout
`define RTCC_SR_BAT 7
`define RTCC_SR_AL1 6
`define RTCC_SR_AL0 5
`define RTCC_SR_REG_WRITE_LATCH 2
`define RTCC_SR_WEL 1
`define RTCC_SR_PLF 0
`define RTCC_SR_RESET 8'h01
`define RTCC_SR_SET_WEL 8'h02
`define RTCC_SR_SET_BOTH 8'h06
`define RTCC_SR_CLEAR 8'h00

// control register layout, nonvolatile fields
`define RTCC_CTRL_PROT_HI 7
`define RTCC_CTRL_PROT_LO 5
`define RTCC_CTRL_WD_HI 4
`define RTCC_CTRL_WD_LO 3
`define RTCC_PROT_DEFAULT 3'h0
`define RTCC_WD_DEFAULT 2'h0

// hour register layout
`define RTCC_HOUR_MIL 7
`define RTCC_HOUR_PM 5

// watchdog periods and reset hold in milliseconds, crystal frequency in hertz
`define RTCC_WD_T0_MS 1750
`define RTCC_WD_T1_MS 750
`define RTCC_WD_T2_MS 250
`define RTCC_WD_HOLD_MS 100
`define RTCC_XTAL_HZ 32768

`endif

/* inc/rtcc_pkg.sv */
// types of the clock/calendar block
// assumes rtcc_regs.svh supplies the numeric constants
package rtcc_pkg;

   typedef enum logic [1:0] {
      RTCC_WD_RUN,
      RTCC_WD_HOLD,
      RTCC_WD_OFF
   } rtcc_wd_state_t;

   typedef struct packed {
      logic xs1; // crystal sync, first stage
      logic xs2;
      logic xprev;
      logic ms1; // supply syncs
      logic ms2;
      logic bs1;
      logic bs2;
      logic [19:0] pre;
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hour;
      logic [7:0] date;
      logic [7:0] mon;
      logic [7:0] year;
      logic [2:0] wday;
      logic [6:0][7:0] shadow;
      logic write_latch;
      logic reg_write_latch;
      logic plf;
      logic backup_supply_flag;
      logic al0;
      logic al1;
      logic al0_snap;
      logic al1_snap;
      logic both_lost;
      logic ccr_wr_pend;
      logic [2:0] prot;
      logic [1:0] wdsel;
      rtcc_wd_state_t wd_st;
      logic [19:0] wd_cnt;
      logic [7:0] rd_data;
   } rtcc_state_t;

endpackage

/* logic/rtcc_bcd_step.sv */
// one BCD field stepped by one with wrap from hi back to lo
// assumes a legal BCD value; anything at or above hi also wraps
`timescale 1ns/1ps
module rtcc_bcd_step (
   input wire logic [7:0] val,
   input wire logic [7:0] lo,
   input wire logic [7:0] hi,
   output logic [7:0] nxt,
   output logic wrap
);
   // ones digit rolls into tens at 9
   always_comb begin
      wrap = (val >= hi);
      if (wrap) begin
         nxt = lo;
      end else if (val[3:0] == 4'h9) begin
         nxt = {val[7:4] + 4'h1, 4'h0};
      end else begin
         nxt = {val[7:4], val[3:0] + 4'h1};
      end
   end
endmodule // rtcc_bcd_step

/* logic/rtcc_core.sv */
// clock/calendar counters, status register, write latches, protect and watchdog
// assumes a serial front end on ref_clk decoding bytes into the strobes below
`timescale 1ns/1ps
`include "rtcc_regs.svh"
module rtcc_core #(
   parameter int XTAL_HZ = `RTCC_XTAL_HZ
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic nv_default,
   input wire logic xtal_clk,
   input wire logic main_supply_ok,
   input wire logic backup_supply_pin,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wr_data,
   output logic reg_wr_ack,
   input wire logic rd_begin,
   output logic [7:0] reg_rd_data,
   input wire logic sr_rd_last_fall,
   input wire logic bus_start,
   input wire logic bus_stop,
   input wire logic alarm0_match,
   input wire logic alarm1_match,
   input wire logic [8:0] arr_addr,
   input wire logic arr_wr,
   output logic arr_wr_ack,
   output logic wd_reset_out
);
   import rtcc_pkg::*;

   // watchdog periods in crystal ticks, derived from the millisecond figures
   localparam logic [19:0] WD_P0 = 20'(`RTCC_WD_T0_MS * XTAL_HZ / 1000);
   localparam logic [19:0] WD_P1 = 20'(`RTCC_WD_T1_MS * XTAL_HZ / 1000);
   localparam logic [19:0] WD_P2 = 20'(`RTCC_WD_T2_MS * XTAL_HZ / 1000);
   localparam logic [19:0] WD_HOLD = 20'(`RTCC_WD_HOLD_MS * XTAL_HZ / 1000);
   localparam logic [19:0] PRE_TOP = 20'(XTAL_HZ - 1);

   rtcc_state_t cur_ff;
   rtcc_state_t nxt_st;

   logic xtick;
   logic sec_tick;
   logic [7:0] sec_n, min_n, h24_n, h12_n, date_n, mon_n, year_n;
   logic sec_w, min_w, h24_w, date_w, mon_w;
   logic [7:0] h12_val;
   logic [7:0] dim;
   logic leap;
   logic [7:0] hour_n;
   logic day_carry;
   logic [19:0] wd_period;
   logic in_clock;
   logic [2:0] clk_idx;
   logic prot_hit;
   logic [7:0] status_val;
   logic [7:0] rd_mux;

   // crystal edges found on the ref_clk side
   assign xtick = cur_ff.xs2 & ~cur_ff.xprev;
   assign sec_tick = xtick && (cur_ff.pre >= PRE_TOP);

   // leap year: two-digit BCD year divisible by four, no century skip
   assign leap = cur_ff.year[4] ? (cur_ff.year[3:0] == 4'h2 || cur_ff.year[3:0] == 4'h6)
                                : (cur_ff.year[3:0] == 4'h0 || cur_ff.year[3:0] == 4'h4 ||
                                   cur_ff.year[3:0] == 4'h8);

   // month length for the date wrap
   always_comb begin
      case (cur_ff.mon)
         8'h02: dim = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: dim = 8'h30;
         default: dim = 8'h31;
      endcase
   end

   // one stepper per field, two for the hour and none for the weekday; the chain below decides which step is taken
   rtcc_bcd_step u_sec (.val(cur_ff.sec), .lo(8'h00), .hi(8'h59), .nxt(sec_n), .wrap(sec_w));
   rtcc_bcd_step u_min (.val(cur_ff.min), .lo(8'h00), .hi(8'h59), .nxt(min_n), .wrap(min_w));
   rtcc_bcd_step u_h24 (.val({2'h0, cur_ff.hour[5:0]}), .lo(8'h00), .hi(8'h23), .nxt(h24_n), .wrap(h24_w));
   assign h12_val = {3'h0, cur_ff.hour[4:0]};
   rtcc_bcd_step u_h12 (.val(h12_val), .lo(8'h01), .hi(8'h12), .nxt(h12_n), .wrap());
   rtcc_bcd_step u_date (.val(cur_ff.date), .lo(8'h01), .hi(dim), .nxt(date_n), .wrap(date_w));
   rtcc_bcd_step u_mon (.val(cur_ff.mon), .lo(8'h01), .hi(8'h12), .nxt(mon_n), .wrap(mon_w));
   rtcc_bcd_step u_year (.val(cur_ff.year), .lo(8'h00), .hi(8'h99), .nxt(year_n), .wrap());

   // hour step in either format; 11 PM to 12 AM is the day boundary in 12-hour mode
   always_comb begin
      hour_n = cur_ff.hour;
      day_carry = 1'b0;
      if (cur_ff.hour[`RTCC_HOUR_MIL]) begin
         hour_n = {1'b1, 1'b0, h24_n[5:0]};
         day_carry = h24_w;
      end else if (h12_val == 8'h11) begin
         hour_n = {1'b0, 1'b0, ~cur_ff.hour[`RTCC_HOUR_PM], 5'h12};
         day_carry = cur_ff.hour[`RTCC_HOUR_PM];
      end else begin
         hour_n = {1'b0, 1'b0, cur_ff.hour[`RTCC_HOUR_PM], h12_n[4:0]};
      end
   end

   // watchdog period from the select field
   always_comb begin
      case (cur_ff.wdsel)
         2'h0: wd_period = WD_P0;
         2'h1: wd_period = WD_P1;
         2'h2: wd_period = WD_P2;
         default: wd_period = 20'h00000;
      endcase
   end

   // array protection ranges
   always_comb begin
      case (cur_ff.prot)
         3'h1: prot_hit = (arr_addr >= 9'h180);
         3'h2: prot_hit = (arr_addr >= 9'h100);
         3'h3: prot_hit = 1'b1;
         3'h4: prot_hit = (arr_addr <= 9'h03F);
         3'h5: prot_hit = (arr_addr <= 9'h07F);
         3'h6: prot_hit = (arr_addr <= 9'h0FF);
         3'h7: prot_hit = 1'b1;
         default: prot_hit = 1'b0;
      endcase
   end

   // array write handshake: no latch or a protected address, no acknowledge
   assign arr_wr_ack = arr_wr && cur_ff.write_latch && !prot_hit;
   assign in_clock = (reg_addr >= `RTCC_ADDR_SEC) && (reg_addr <= `RTCC_ADDR_WDAY);
   assign clk_idx = 3'(reg_addr - `RTCC_ADDR_SEC);

   // status byte; bits 3 and 4 always zero
   assign status_val = {cur_ff.backup_supply_flag, cur_ff.al1, cur_ff.al0, 2'b00,
                        cur_ff.reg_write_latch, cur_ff.write_latch, cur_ff.plf};

   // status writes are always taken; map writes need the write latch
   assign reg_wr_ack = reg_wr && ((reg_addr == `RTCC_ADDR_STATUS) || cur_ff.write_latch);

   // read data: clock bytes from the shadow so a rollover cannot tear a read
   always_comb begin
      if (in_clock) begin
         rd_mux = cur_ff.shadow[clk_idx];
      end else if (reg_addr == `RTCC_ADDR_STATUS) begin
         rd_mux = status_val;
      end else if (reg_addr == `RTCC_ADDR_CTRL) begin
         rd_mux = {cur_ff.prot, cur_ff.wdsel, 3'h0};
      end else begin
         rd_mux = 8'h00;
      end
   end

   // next state of the whole block
   always_comb begin
      nxt_st = cur_ff;
      // two-flop syncs for the crystal and both supply pins
      nxt_st.xs1 = xtal_clk;
      nxt_st.xs2 = cur_ff.xs1;
      nxt_st.xprev = cur_ff.xs2;
      nxt_st.ms1 = main_supply_ok;
      nxt_st.ms2 = cur_ff.ms1;
      nxt_st.bs1 = backup_supply_pin;
      nxt_st.bs2 = cur_ff.bs1;
      nxt_st.rd_data = rd_mux;

      // seconds prescaler on crystal edges
      if (xtick) begin
         nxt_st.pre = sec_tick ? 20'h00000 : cur_ff.pre + 20'h00001;
      end

      // calendar carry chain
      if (sec_tick) begin
         nxt_st.sec = sec_n;
         if (sec_w) begin
            nxt_st.min = min_n;
            if (min_w) begin
               nxt_st.hour = hour_n;
               if (day_carry) begin
                  nxt_st.wday = (cur_ff.wday >= 3'h6) ? 3'h0 : cur_ff.wday + 3'h1;
                  nxt_st.date = date_n;
                  if (date_w) begin
                     nxt_st.mon = mon_n;
                     if (mon_w) begin
                        nxt_st.year = year_n;
                     end
                  end
               end
            end
         end
      end

      // snapshot at the start of a read
      if (rd_begin) begin
         nxt_st.shadow = {5'h00, cur_ff.wday, cur_ff.year, cur_ff.mon, cur_ff.date,
                          cur_ff.hour, cur_ff.min, cur_ff.sec};
         if (reg_addr == `RTCC_ADDR_STATUS) begin
            nxt_st.al0_snap = cur_ff.al0;
            nxt_st.al1_snap = cur_ff.al1;
         end
      end

      // alarm flags: clear only what was seen at read start; a new match wins
      if (sr_rd_last_fall) begin
         if (cur_ff.al0_snap) nxt_st.al0 = 1'b0;
         if (cur_ff.al1_snap) nxt_st.al1 = 1'b0;
         nxt_st.al0_snap = 1'b0;
         nxt_st.al1_snap = 1'b0;
      end
      if (alarm0_match) nxt_st.al0 = 1'b1;
      if (alarm1_match) nxt_st.al1 = 1'b1;

      // backup flag follows the synced supply levels
      nxt_st.backup_supply_flag = ~cur_ff.ms2 & cur_ff.bs2;

      // register writes
      if (reg_wr) begin
         if (reg_addr == `RTCC_ADDR_STATUS) begin
            // latch writes take effect at once, no write cycle
            if (reg_wr_data == `RTCC_SR_SET_WEL) begin
               nxt_st.write_latch = 1'b1;
            end else if (reg_wr_data == `RTCC_SR_SET_BOTH && cur_ff.write_latch) begin
               nxt_st.reg_write_latch = 1'b1;
            end else if (reg_wr_data == `RTCC_SR_CLEAR) begin
               nxt_st.write_latch = 1'b0;
               nxt_st.reg_write_latch = 1'b0;
            end
         end else if (cur_ff.write_latch && cur_ff.reg_write_latch) begin
            nxt_st.ccr_wr_pend = 1'b1;
            if (in_clock) begin
               nxt_st.plf = 1'b0;
               case (clk_idx)
                  3'h0: nxt_st.sec = reg_wr_data;
                  3'h1: nxt_st.min = reg_wr_data;
                  3'h2: nxt_st.hour = reg_wr_data;
                  3'h3: nxt_st.date = reg_wr_data;
                  3'h4: nxt_st.mon = reg_wr_data;
                  3'h5: nxt_st.year = reg_wr_data;
                  default: nxt_st.wday = reg_wr_data[2:0];
               endcase
            end else if (reg_addr == `RTCC_ADDR_CTRL) begin
               nxt_st.prot = reg_wr_data[`RTCC_CTRL_PROT_HI:`RTCC_CTRL_PROT_LO];
               nxt_st.wdsel = reg_wr_data[`RTCC_CTRL_WD_HI:`RTCC_CTRL_WD_LO];
            end
         end
      end

      // a finished map write drops the register latch at the stop
      if (bus_stop && cur_ff.ccr_wr_pend) begin
         nxt_st.reg_write_latch = 1'b0;
         nxt_st.ccr_wr_pend = 1'b0;
      end

      // total loss: both supplies gone; flag rises when either returns
      if (!cur_ff.ms2 && !cur_ff.bs2) begin
         nxt_st.both_lost = 1'b1;
      end else if (cur_ff.both_lost) begin
         nxt_st.both_lost = 1'b0;
         nxt_st.plf = 1'b1;
      end

      // watchdog: starts reload, ticks count down, expiry holds reset
      case (cur_ff.wd_st)
         RTCC_WD_RUN: begin
            if (wd_period == 20'h00000) begin
               nxt_st.wd_st = RTCC_WD_OFF;
            end else if (bus_start) begin
               nxt_st.wd_cnt = wd_period;
            end else if (xtick) begin
               if (cur_ff.wd_cnt <= 20'h00001) begin
                  nxt_st.wd_st = RTCC_WD_HOLD;
                  nxt_st.wd_cnt = WD_HOLD;
               end else begin
                  nxt_st.wd_cnt = cur_ff.wd_cnt - 20'h00001;
               end
            end
         end
         RTCC_WD_HOLD: begin
            // starts during the reset hold are ignored
            if (xtick) begin
               if (cur_ff.wd_cnt <= 20'h00001) begin
                  nxt_st.wd_st = RTCC_WD_RUN;
                  nxt_st.wd_cnt = wd_period;
               end else begin
                  nxt_st.wd_cnt = cur_ff.wd_cnt - 20'h00001;
               end
            end
         end
         RTCC_WD_OFF: begin
            if (wd_period != 20'h00000) begin
               nxt_st.wd_st = RTCC_WD_RUN;
               nxt_st.wd_cnt = wd_period;
            end
         end
         default: nxt_st.wd_st = RTCC_WD_RUN;
      endcase

      // power-up: volatile state to defaults, nonvolatile fields kept unless nv_default is set
      if (reset) begin
         nxt_st.xs1 = 1'b0;
         nxt_st.xs2 = 1'b0;
         nxt_st.xprev = 1'b0;
         nxt_st.ms1 = 1'b1; // supplies assumed up, so no false total loss
         nxt_st.ms2 = 1'b1;
         nxt_st.bs1 = 1'b1;
         nxt_st.bs2 = 1'b1;
         nxt_st.pre = 20'h00000;
         nxt_st.sec = 8'h00;
         nxt_st.min = 8'h00;
         nxt_st.hour = 8'h00;
         nxt_st.date = 8'h00;
         nxt_st.mon = 8'h00;
         nxt_st.year = 8'h00;
         nxt_st.wday = 3'h0;
         nxt_st.shadow = '0;
         nxt_st.write_latch = 1'b0;
         nxt_st.reg_write_latch = 1'b0;
         nxt_st.plf = 1'(`RTCC_SR_RESET >> `RTCC_SR_PLF);
         nxt_st.backup_supply_flag = 1'b0;
         nxt_st.al0 = 1'b0;
         nxt_st.al1 = 1'b0;
         nxt_st.al0_snap = 1'b0;
         nxt_st.al1_snap = 1'b0;
         nxt_st.both_lost = 1'b0;
         nxt_st.ccr_wr_pend = 1'b0;
         nxt_st.wd_st = RTCC_WD_RUN;
         nxt_st.wd_cnt = WD_P0;
         nxt_st.rd_data = 8'h00;
         // survives reset unless defaults are forced
         if (nv_default) begin
            nxt_st.prot = `RTCC_PROT_DEFAULT;
            nxt_st.wdsel = `RTCC_WD_DEFAULT;
         end
      end
   end

   // the single state register; nonvolatile fields hold through reset unless nv_default is set
   always_ff @(posedge ref_clk) begin
      cur_ff <= nxt_st;
   end

   assign reg_rd_data = cur_ff.rd_data;
   assign wd_reset_out = (cur_ff.wd_st == RTCC_WD_HOLD);

endmodule // rtcc_core

/* test/rtcc_core_checker.sv */
// port assertions for the clock/calendar core
// assumes bind onto rtcc_core, everything on ref_clk with sync reset
`timescale 1ns/1ps
module rtcc_core_checker (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic nv_default,
   input wire logic main_supply_ok,
   input wire logic backup_supply_pin,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wr_data,
   input wire logic reg_wr_ack,
   input wire logic [7:0] reg_rd_data,
   input wire logic sr_rd_last_fall,
   input wire logic bus_start,
   input wire logic bus_stop,
   input wire logic alarm0_match,
   input wire logic [8:0] arr_addr,
   input wire logic arr_wr,
   input wire logic arr_wr_ack,
   input wire logic wd_reset_out
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   logic wel_ff;
   logic reg_write_latch_ff;
   logic [2:0] prot_ff;
   logic prot_range_hit;
   // write latch mirrored from status writes; 06h leaves it as it was
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wel_ff <= 1'b0;
      end else if (reg_wr && reg_addr == 8'h3F && reg_wr_data == 8'h02) begin
         wel_ff <= 1'b1;
      end else if (reg_wr && reg_addr == 8'h3F && reg_wr_data == 8'h00) begin
         wel_ff <= 1'b0;
      end
   end
   // register latch and protect field mirrored; a stop ends the map write
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         reg_write_latch_ff <= 1'b0;
         if (nv_default) begin
            prot_ff <= 3'h0;
         end
      end else if (reg_wr && reg_addr == 8'h3F && reg_wr_data == 8'h06 && wel_ff) begin
         reg_write_latch_ff <= 1'b1;
      end else if ((reg_wr && reg_addr == 8'h3F && reg_wr_data == 8'h00) || bus_stop) begin
         reg_write_latch_ff <= 1'b0;
      end else if (reg_wr && reg_addr == 8'h10 && wel_ff && reg_write_latch_ff) begin
         prot_ff <= reg_wr_data[7:5];
      end
   end
   // protected array ranges per protect code
   assign prot_range_hit = (prot_ff == 3'h3) || (prot_ff == 3'h7) ||
      (prot_ff == 3'h1 && arr_addr >= 9'h180) || (prot_ff == 3'h2 && arr_addr >= 9'h100) ||
      (prot_ff == 3'h4 && arr_addr <= 9'h03F) || (prot_ff == 3'h5 && arr_addr <= 9'h07F) ||
      (prot_ff == 3'h6 && arr_addr <= 9'h0FF);
   // status address held, then a flag event seen through the read path
   sequence sr_held;
      reg_addr == 8'h3F;
   endsequence
   sequence al0_seen;
      alarm0_match && reg_addr == 8'h3F ##1 reg_addr == 8'h3F && !sr_rd_last_fall;
   endsequence
   sequence on_backup;
      (!main_supply_ok && backup_supply_pin && reg_addr == 8'h3F) [*5];
   endsequence
   AST_SR_WR_ACK: assert property (reg_wr && reg_addr == 8'h3F |-> reg_wr_ack)
      else $error("status write not acknowledged");
   AST_WR_NO_ACK: assert property (reg_wr && reg_addr != 8'h3F && !wel_ff |-> !reg_wr_ack)
      else $error("write acknowledged with write latch low");
   AST_ARR_ACK: assert property (arr_wr_ack == (arr_wr && wel_ff && !prot_range_hit))
      else $error("array acknowledge differs from write latch");
   AST_SR_ZERO: assert property (sr_held |=> reg_rd_data[4:3] == 2'h0)
      else $error("status bits 4:3 not zero");
   AST_SEC_RANGE: assert property (reg_addr == 8'h30 |=>
      !reg_rd_data[7] && reg_rd_data[6:4] <= 3'h5 && reg_rd_data[3:0] <= 4'h9)
      else $error("seconds out of range");
   AST_WDAY_RANGE: assert property (reg_addr == 8'h36 |=> reg_rd_data <= 8'h06)
      else $error("weekday out of range");
   AST_ALARM_SET: assert property (al0_seen |=> reg_rd_data[5])
      else $error("alarm flag not set after match");
   AST_BAT: assert property (on_backup |=> reg_rd_data[7])
      else $error("backup flag low while on backup supply");
   AST_WD_HOLD: assert property ($rose(wd_reset_out) |-> wd_reset_out [*4])
      else $error("watchdog reset too short");
   AST_START_RELOAD: assert property (bus_start && !wd_reset_out |=> !wd_reset_out [*8])
      else $error("watchdog fired right after a start");
endmodule // rtcc_core_checker

bind rtcc_core rtcc_core_checker chk_u (.ref_clk(ref_clk), .reset(reset), .nv_default(nv_default),
   .main_supply_ok(main_supply_ok), .backup_supply_pin(backup_supply_pin), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_wr_data(reg_wr_data), .reg_wr_ack(reg_wr_ack), .reg_rd_data(reg_rd_data),
   .sr_rd_last_fall(sr_rd_last_fall), .bus_start(bus_start), .bus_stop(bus_stop),
   .alarm0_match(alarm0_match), .arr_addr(arr_addr), .arr_wr(arr_wr), .arr_wr_ack(arr_wr_ack),
   .wd_reset_out(wd_reset_out));

/* test/rtcc_host.sv */
// host model: byte writes, reads and bus conditions toward the core
// assumes core samples on ref_clk rising edge; host drives on falling edge
`timescale 1ns/1ps
module rtcc_host (
   input wire logic ref_clk,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wr_data,
   input wire logic reg_wr_ack,
   output logic rd_begin,
   input wire logic [7:0] reg_rd_data,
   output logic sr_rd_last_fall,
   output logic bus_start,
   output logic bus_stop
);
   logic [2:0] cond;
   assign bus_start = cond[0];
   assign bus_stop = cond[1];
   assign sr_rd_last_fall = cond[2];
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wr_data = 8'hFF;
      rd_begin = 1'b0;
      cond = 3'h0;
   end
   // one byte; released data shows the inverse so stale bytes never look valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ack);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wr_data = d;
      reg_wr = 1'b1;
      #1;
      ack = reg_wr_ack;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      reg_wr_data = ~d;
   endtask
   // first=1 latches the time buffer, and the alarm snapshot when a is the status address
   task automatic rd(input logic [7:0] a, input logic first, output logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      rd_begin = first;
      @(negedge ref_clk);
      rd_begin = 1'b0;
      @(negedge ref_clk);
      d = reg_rd_data;
   endtask
   // k: 0 start, 1 stop, 2 last status bit falling
   task automatic pulse(input int k);
      @(negedge ref_clk);
      cond[k] = 1'b1;
      @(negedge ref_clk);
      cond = 3'h0;
   endtask
   // both latches in order, zeros elsewhere in the byte
   task automatic unlock();
      logic ack;
      wr(8'h3F, 8'h02, ack);
      wr(8'h3F, 8'h06, ack);
   endtask
endmodule // rtcc_host

/* test/rtcc_core_tb.sv */
// self-checking bench for the clock/calendar core driven by the host model
// assumes XTAL_HZ of 16: one second is 128 ref_clk cycles
`timescale 1ns/1ps
module rtcc_core_tb;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic nv_default = 1'b1;
   logic xtal_clk = 1'b0;
   logic main_supply_ok = 1'b1;
   logic backup_supply_pin = 1'b1;
   logic alarm0_match = 1'b0;
   logic alarm1_match = 1'b0;
   logic [8:0] arr_addr = 9'h1FF;
   logic arr_wr = 1'b0;
   logic [7:0] reg_addr, reg_wr_data, reg_rd_data, v;
   logic reg_wr, reg_wr_ack, rd_begin, sr_rd_last_fall, bus_start, bus_stop, arr_wr_ack, wd_reset_out, ack;
   int n_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   int cnt;
   int tks [4] = '{28, 12, 4, 0};
   // date, month, year, weekday before midnight, then after
   logic [7:0] tbl [4][8] = '{'{8'h28, 8'h02, 8'h04, 8'h03, 8'h29, 8'h02, 8'h04, 8'h04},
      '{8'h28, 8'h02, 8'h05, 8'h06, 8'h01, 8'h03, 8'h05, 8'h00},
      '{8'h31, 8'h12, 8'h99, 8'h01, 8'h01, 8'h01, 8'h00, 8'h02},
      '{8'h30, 8'h04, 8'h07, 8'h00, 8'h01, 8'h05, 8'h07, 8'h01}};
   rtcc_core #(.XTAL_HZ(16)) dut_u (.ref_clk(ref_clk), .reset(reset), .nv_default(nv_default),
      .xtal_clk(xtal_clk), .main_supply_ok(main_supply_ok), .backup_supply_pin(backup_supply_pin),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wr_data(reg_wr_data), .reg_wr_ack(reg_wr_ack),
      .rd_begin(rd_begin), .reg_rd_data(reg_rd_data), .sr_rd_last_fall(sr_rd_last_fall),
      .bus_start(bus_start), .bus_stop(bus_stop), .alarm0_match(alarm0_match), .alarm1_match(alarm1_match),
      .arr_addr(arr_addr), .arr_wr(arr_wr), .arr_wr_ack(arr_wr_ack), .wd_reset_out(wd_reset_out));
   rtcc_host host_u (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wr_data(reg_wr_data),
      .reg_wr_ack(reg_wr_ack), .rd_begin(rd_begin), .reg_rd_data(reg_rd_data),
      .sr_rd_last_fall(sr_rd_last_fall), .bus_start(bus_start), .bus_stop(bus_stop));
   // system clock and a free-running crystal at one eighth of its rate, edges on ref_clk falling edges
   always #5 ref_clk = ~ref_clk;
   always #40 xtal_clk = ~xtal_clk;
   task automatic test_done();
      if (n_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic arr_try(input logic [7:0] exp);
      @(negedge ref_clk);
      arr_wr = 1'b1;
      #1;
      check({7'h0, arr_wr_ack}, exp);
      @(negedge ref_clk);
      arr_wr = 1'b0;
   endtask
   task automatic set_ctrl(input logic [7:0] d);
      host_u.unlock();
      host_u.wr(8'h10, d, ack);
      host_u.pulse(1);
   endtask
   task automatic power_cycle(input logic nvd);
      nv_default = nvd;
      reset = 1'b1;
      repeat (6) @(negedge ref_clk);
      reset = 1'b0;
   endtask
   // hang guard well above the expected run length
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         test_done();
      end
   end
   initial begin
      repeat (6) @(negedge ref_clk);
      reset = 1'b0;
      host_u.rd(8'h3F, 1'b1, v);
      check(v, 8'h01);
      host_u.wr(8'h30, 8'h12, ack);
      check({7'h0, ack}, 8'h00);
      host_u.wr(8'h3F, 8'h06, ack);
      host_u.rd(8'h3F, 1'b0, v);
      check(v, 8'h01);
      arr_try(8'h00);
      host_u.wr(8'h3F, 8'h02, ack);
      check({7'h0, ack}, 8'h01);
      host_u.rd(8'h3F, 1'b0, v);
      check(v, 8'h03);
      arr_try(8'h01);
      host_u.wr(8'h3F, 8'h06, ack);
      host_u.rd(8'h3F, 1'b0, v);
      check(v, 8'h07);
      // seconds written last so a tick mid-sequence cannot carry
      for (int i = 0; i < 4; i++) begin
         host_u.unlock();
         for (int a = 6; a >= 0; a--) begin
            host_u.wr(8'h30 + 8'(a), (a > 2) ? tbl[i][a - 3] : ((a == 2) ? 8'hA3 : 8'h59), ack);
         end
         host_u.pulse(1);
         host_u.rd(8'h3F, 1'b0, v);
         check(v, 8'h02);
         repeat (140) @(negedge ref_clk);
         host_u.rd(8'h30, 1'b1, v);
         check(v & 8'hFE, 8'h00);
         host_u.rd(8'h31, 1'b0, v);
         check(v, 8'h00);
         host_u.rd(8'h32, 1'b0, v);
         check(v, 8'h80);
         for (int a = 3; a < 7; a++) begin
            host_u.rd(8'h30 + 8'(a), 1'b0, v);
            check(v, tbl[i][a + 1]);
         end
      end
      host_u.rd(8'h20, 1'b0, v);
      check(v, 8'h00);
      host_u.rd(8'h3F, 1'b0, v);
      check(v & 8'h60, 8'h00);
      // alarm 1 arrives after the status read has begun
      @(negedge ref_clk);
      alarm0_match = 1'b1;
      @(negedge ref_clk);
      alarm0_match = 1'b0;
      host_u.rd(8'h3F, 1'b1, v);
      check(v & 8'h60, 8'h20);
      alarm1_match = 1'b1;
      @(negedge ref_clk);
      alarm1_match = 1'b0;
      host_u.pulse(2);
      host_u.rd(8'h3F, 1'b0, v);
      check(v & 8'h60, 8'h40);
      main_supply_ok = 1'b0;
      repeat (8) @(negedge ref_clk);
      host_u.rd(8'h3F, 1'b0, v);
      check(v & 8'h81, 8'h80);
      main_supply_ok = 1'b1;
      backup_supply_pin = 1'b0;
      repeat (8) @(negedge ref_clk);
      main_supply_ok = 1'b0;
      repeat (8) @(negedge ref_clk);
      main_supply_ok = 1'b1;
      repeat (8) @(negedge ref_clk);
      host_u.rd(8'h3F, 1'b0, v);
      check(v & 8'h81, 8'h01);
      // each watchdog select, expiry timed from a single start; select 3 checked for no expiry within 300 cycles
      for (int s = 0; s < 4; s++) begin
         set_ctrl({3'h0, 2'(s), 3'h0});
         host_u.rd(8'h10, 1'b0, v);
         check(v, {3'h0, 2'(s), 3'h0});
         host_u.pulse(0); // reload first so the timed start cannot meet an expiry
         while (wd_reset_out === 1'b1) @(negedge ref_clk);
         host_u.pulse(0);
         cnt = 0;
         while (wd_reset_out !== 1'b1 && cnt < 300) begin
            @(negedge ref_clk);
            cnt++;
         end
         if (s == 3)
            check(8'(cnt / 4), 8'h4B);
         else
            check({7'h0, cnt >= (tks[s] - 1) * 8 && cnt <= (tks[s] + 2) * 8}, 8'h01);
      end
      set_ctrl(8'hB8);
      arr_addr = 9'h07F;
      arr_try(8'h00);
      arr_addr = 9'h080;
      arr_try(8'h01);
      power_cycle(1'b0);
      host_u.rd(8'h10, 1'b0, v);
      check(v, 8'hB8);
      power_cycle(1'b1);
      host_u.rd(8'h10, 1'b0, v);
      check(v, 8'h00);
      test_done();
   end
endmodule // rtcc_core_tb
